// ===== include/bp_cmd_pkg.sv
// Package with map, command codes and timing for the boot partition command port.
package bp_cmd_pkg;
    localparam logic [15:0] BOOT_LO_END      = 16'h01FF;
    localparam logic [15:0] BOOT_HI_START    = 16'h8000;
    localparam logic [15:0] BOOT_HI_END      = 16'h800F;
    localparam logic [15:0] ECC_SPARE3_ADDR  = 16'hFF08;
    localparam logic [15:0] ECC_RESET_VAL    = 16'h0000;
    localparam logic [15:0] CMD_RESET        = 16'h00F0;
    localparam logic [15:0] CMD_LOAD         = 16'h00E0;
    localparam logic [15:0] CMD_LOAD_2ND     = 16'h0000;
    localparam logic [15:0] CMD_IDENT        = 16'h0090;
    localparam logic [15:0] ID_MAKER_ADDR    = 16'h0000;
    localparam logic [15:0] ID_DEVICE_ADDR   = 16'h0001;
    localparam logic [15:0] ID_WP_ADDR       = 16'h0002;
    localparam int          SEL_LSB          = 4;
    localparam int          LANE_LSB         = 0;
    localparam logic [1:0]  SEL_WORD2        = 2'h0;
    localparam logic [1:0]  SEL_WORD3        = 2'h1;
    localparam int          PAGE_BITS        = 6;
    localparam int          BLOCK_BITS       = 10;
    localparam logic [7:0]  LOAD_CYCLES      = 8'h20;
    localparam logic [7:0]  RESET_CYCLES     = 8'h04;
    localparam logic [15:0] BOOT_BUF_WORDS   = 16'h0200;
    typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_READ} host_op_t;
endpackage

// ===== include/bp_bus_if.sv
// Interface carrying the parallel flash bus between host and device.
`timescale 1ns/1ps
interface bp_bus_if;
    logic        chip_sel_n;
    logic        out_en_n;
    logic        write_n;
    logic        address_valid_n;
    logic        warm_reset_pin_n;
    logic        burst_clk;
    logic [15:0] address_bus;
    logic [15:0] data_bus_h;
    logic        data_bus_h_oe;
    logic [15:0] data_bus_d;
    logic        data_bus_d_oe;
    logic        busy;
    logic [15:0] data_bus;
    // Wire level from the enables; undriven bus reads as zero.
    assign data_bus = data_bus_d_oe ? data_bus_d : (data_bus_h_oe ? data_bus_h : 16'h0000);
    modport device (input chip_sel_n, out_en_n, write_n, address_valid_n, warm_reset_pin_n,
                    burst_clk, address_bus, data_bus, output data_bus_d, data_bus_d_oe, busy);
    modport host (output chip_sel_n, out_en_n, write_n, address_valid_n, warm_reset_pin_n,
                  burst_clk, address_bus, data_bus_h, data_bus_h_oe, input data_bus, busy);
endinterface

// ===== hw/bp_cmd_device.sv
// Device end: boot partition command decoder with spare ECC result register.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module bp_cmd_device #(
    parameter logic [15:0] MAKER_ID  = 16'h1234,
    parameter logic [15:0] DEVICE_ID = 16'h5678,
    parameter int          BUF_WORDS = 64
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    bp_bus_if.device         bus,
    input  wire logic [1:0]  ecc_sel_in,
    input  wire logic [3:0]  ecc_lane_in,
    input  wire logic        ecc_valid_in,
    input  wire logic        block_locked,
    output logic [15:0]      block_addr_field,
    output logic [5:0]       page_addr_field,
    output logic             load_done
);
    typedef enum logic [2:0] {S_READY, S_LOAD2, S_IDENT, S_LOAD_RUN, S_RESET_RUN} dstate_t;

    // Two-flop synchronisers for every bus pin; only the second stage is read.
    logic [21:0] pin_s1_r;
    logic [21:0] pin_s2_r;
    logic [15:0] data_s1_r;
    logic [15:0] data_s2_r;
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_s1_r  <= {22{1'b1}};
            pin_s2_r  <= {22{1'b1}};
            data_s1_r <= 16'h0000;
            data_s2_r <= 16'h0000;
        end
        else
        begin
            pin_s1_r  <= {bus.chip_sel_n, bus.out_en_n, bus.write_n, bus.address_valid_n,
                          bus.warm_reset_pin_n, bus.burst_clk, bus.address_bus};
            pin_s2_r  <= pin_s1_r;
            data_s1_r <= bus.data_bus;
            data_s2_r <= data_s1_r;
        end
    end

    logic        cs_n;
    logic        oe_n;
    logic        we_n;
    logic        rp_n;
    logic [15:0] addr;
    assign cs_n = pin_s2_r[21];
    assign oe_n = pin_s2_r[20];
    assign we_n = pin_s2_r[19];
    assign rp_n = pin_s2_r[17];
    assign addr = pin_s2_r[15:0];

    // Decoder state; the write is taken on the rising edge of the strobe so data is settled.
    dstate_t     state_r,  state_nxt;
    logic        we_d_r,   we_d_nxt;
    logic        cmd_seen_r, cmd_seen_nxt;
    logic [5:0]  page_r,   page_nxt;
    logic [15:0] block_r,  block_nxt;
    logic [5:0]  ecc3_r,   ecc3_nxt;
    logic [7:0]  cnt_r,    cnt_nxt;
    logic        done_r,   done_nxt;
    logic [15:0] mem_r [BUF_WORDS];
    logic [15:0] dout_r,   dout_nxt;
    logic        oe_r,     oe_nxt;
    logic        in_boot;
    logic        wr_evt;
    logic        wr_boot;

    assign in_boot = (addr <= bp_cmd_pkg::BOOT_LO_END) ||
                     (addr >= bp_cmd_pkg::BOOT_HI_START && addr <= bp_cmd_pkg::BOOT_HI_END);
    assign wr_evt  = !cs_n && we_n && !we_d_r;
    assign wr_boot = wr_evt && in_boot;

    always_comb
    begin
        state_nxt    = state_r;
        we_d_nxt     = we_n;
        cmd_seen_nxt = cmd_seen_r;
        page_nxt     = page_r;
        block_nxt    = block_r;
        ecc3_nxt     = ecc3_r;
        cnt_nxt      = cnt_r;
        done_nxt     = 1'b0;
        unique case (state_r)
            S_READY, S_LOAD2, S_IDENT:
            begin
                if (state_r == S_IDENT && wr_evt)
                    state_nxt = S_READY;
                if (wr_boot)
                begin
                    cmd_seen_nxt = 1'b1;
                    ecc3_nxt     = 6'h00;
                    if (state_r == S_LOAD2)
                    begin
                        // Only the exact second cycle starts the load.
                        if (data_s2_r == bp_cmd_pkg::CMD_LOAD_2ND)
                        begin
                            state_nxt = S_LOAD_RUN;
                            cnt_nxt   = bp_cmd_pkg::LOAD_CYCLES;
                        end
                        else
                            state_nxt = S_READY;
                    end
                    else if (data_s2_r == bp_cmd_pkg::CMD_RESET)
                    begin
                        state_nxt = S_RESET_RUN;
                        cnt_nxt   = bp_cmd_pkg::RESET_CYCLES;
                    end
                    else if (data_s2_r == bp_cmd_pkg::CMD_LOAD)
                        state_nxt = S_LOAD2;
                    else if (data_s2_r == bp_cmd_pkg::CMD_IDENT)
                        state_nxt = S_IDENT;
                    else
                        state_nxt = S_READY;
                end
                else if (wr_evt && state_r == S_LOAD2)
                    state_nxt = S_READY;
            end
            S_LOAD_RUN:
            begin
                // Load runs for a fixed time; command strobes are ignored while busy.
                cnt_nxt = cnt_r - 8'h01;
                if (ecc_valid_in)
                    ecc3_nxt = {ecc_sel_in, ecc_lane_in};
                if (cnt_r == 8'h01)
                begin
                    state_nxt = S_READY;
                    page_nxt  = page_r + 6'h01;
                    done_nxt  = 1'b1;
                end
            end
            S_RESET_RUN:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    state_nxt    = S_READY;
                    page_nxt     = 6'h00;
                    block_nxt    = 16'h0000;
                    ecc3_nxt     = 6'h00;
                    cmd_seen_nxt = 1'b0;
                end
            end
            default: state_nxt = S_READY;
        endcase
        if (!rp_n)
            state_nxt = S_READY;
    end

    // Data buffer storage: writes outside the boot partition are plain data.
    // The buffer is small, so every data address aliases onto it by its low bits.
    always_ff @(posedge core_clk)
    begin
        if (wr_evt && !in_boot)
            mem_r[addr[$clog2(BUF_WORDS)-1:0]] <= data_s2_r;
    end

    // Read data mux; boot partition reads return the page field only until a command is issued, and again once a reset command ends.
    always_comb
    begin
        dout_nxt = 16'h0000;
        if (state_r == S_IDENT)
        begin
            if (addr == bp_cmd_pkg::ID_MAKER_ADDR)
                dout_nxt = MAKER_ID;
            else if (addr == bp_cmd_pkg::ID_DEVICE_ADDR)
                dout_nxt = DEVICE_ID;
            else if (addr == bp_cmd_pkg::ID_WP_ADDR)
                dout_nxt = {15'h0000, block_locked};
        end
        else if (addr == bp_cmd_pkg::ECC_SPARE3_ADDR)
            dout_nxt = {10'h000, ecc3_r};
        else if (in_boot)
            dout_nxt = cmd_seen_r ? 16'h0000 : {10'h000, page_r};
        else
            dout_nxt = mem_r[addr[$clog2(BUF_WORDS)-1:0]];
        oe_nxt = !cs_n && !oe_n && we_n && rp_n;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r    <= S_READY;
            we_d_r     <= 1'b1;
            cmd_seen_r <= 1'b0;
            page_r     <= 6'h00;
            block_r    <= 16'h0000;
            ecc3_r     <= bp_cmd_pkg::ECC_RESET_VAL[5:0];
            cnt_r      <= 8'h00;
            done_r     <= 1'b0;
            dout_r     <= 16'h0000;
            oe_r       <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            we_d_r     <= we_d_nxt;
            cmd_seen_r <= cmd_seen_nxt;
            page_r     <= page_nxt;
            block_r    <= block_nxt;
            ecc3_r     <= ecc3_nxt;
            cnt_r      <= cnt_nxt;
            done_r     <= done_nxt;
            dout_r     <= dout_nxt;
            oe_r       <= oe_nxt;
        end
    end

    assign bus.data_bus_d    = dout_r;
    assign bus.data_bus_d_oe = oe_r;
    assign bus.busy          = (state_r == S_LOAD_RUN) || (state_r == S_RESET_RUN);
    assign block_addr_field  = block_r;
    assign page_addr_field   = page_r;
    assign load_done         = done_r;
endmodule

// ===== hw/bp_cmd_host.sv
// Host end: runs one bus write or read per software order, slowly enough for the device.
`timescale 1ns/1ps
module bp_cmd_host #(
    parameter logic [7:0] PHASE_CYCLES = 8'h06
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    bp_bus_if.host           bus,
    input  wire logic [15:0] sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [15:0]      sw_rdata,
    output logic             sw_busy
);
    typedef enum logic [1:0] {H_IDLE, H_ASSERT, H_RELEASE} hstate_t;

    hstate_t               st_r,  st_nxt;
    bp_cmd_pkg::host_op_t  op_r,  op_nxt;
    logic [15:0]           a_r,   a_nxt;
    logic [15:0]           d_r,   d_nxt;
    logic [15:0]           rd_r,  rd_nxt;
    logic [7:0]            cnt_r, cnt_nxt;
    logic [15:0]           rd_s1_r;
    logic [15:0]           rd_s2_r;

    // Read data comes from another timing domain; two flops before use.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rd_s1_r <= 16'h0000;
            rd_s2_r <= 16'h0000;
        end
        else
        begin
            rd_s1_r <= bus.data_bus;
            rd_s2_r <= rd_s1_r;
        end
    end

    // Each phase is held long enough for the device synchronisers to settle.
    always_comb
    begin
        st_nxt  = st_r;
        op_nxt  = op_r;
        a_nxt   = a_r;
        d_nxt   = d_r;
        rd_nxt  = rd_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            H_IDLE:
                if ((sw_wr || sw_rd) && !bus.busy)
                begin
                    op_nxt  = sw_wr ? bp_cmd_pkg::OP_WRITE : bp_cmd_pkg::OP_READ;
                    a_nxt   = sw_addr;
                    d_nxt   = sw_wdata;
                    cnt_nxt = PHASE_CYCLES;
                    st_nxt  = H_ASSERT;
                end
            H_ASSERT:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    if (op_r == bp_cmd_pkg::OP_READ)
                        rd_nxt = rd_s2_r;
                    cnt_nxt = PHASE_CYCLES;
                    st_nxt  = H_RELEASE;
                end
            end
            H_RELEASE:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    op_nxt = bp_cmd_pkg::OP_NONE;
                    st_nxt = H_IDLE;
                end
            end
            default: st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st_r  <= H_IDLE;
            op_r  <= bp_cmd_pkg::OP_NONE;
            a_r   <= 16'h0000;
            d_r   <= 16'h0000;
            rd_r  <= 16'h0000;
            cnt_r <= 8'h00;
        end
        else
        begin
            st_r  <= st_nxt;
            op_r  <= op_nxt;
            a_r   <= a_nxt;
            d_r   <= d_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Strobes are decoded from registered state; address held across the whole access.
    assign bus.chip_sel_n       = (op_r == bp_cmd_pkg::OP_NONE);
    assign bus.write_n          = !(st_r == H_ASSERT && op_r == bp_cmd_pkg::OP_WRITE);
    assign bus.out_en_n         = !(st_r == H_ASSERT && op_r == bp_cmd_pkg::OP_READ);
    assign bus.address_valid_n  = 1'b0;
    assign bus.warm_reset_pin_n = 1'b1;
    assign bus.burst_clk        = 1'b0;
    assign bus.address_bus      = a_r;
    assign bus.data_bus_h       = d_r;
    assign bus.data_bus_h_oe    = (op_r == bp_cmd_pkg::OP_WRITE);
    assign sw_rdata             = rd_r;
    assign sw_busy              = (st_r != H_IDLE);
endmodule

// ===== tb/bp_cmd_props.sv
// Checker of the bus between the host end and the device end.
`timescale 1ns/1ps
module bp_cmd_props (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        chip_sel_n,
    input wire logic        out_en_n,
    input wire logic        write_n,
    input wire logic        warm_reset_pin_n,
    input wire logic [15:0] address_bus,
    input wire logic        data_bus_d_oe,
    input wire logic        busy,
    input wire logic [15:0] data_bus
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic boot;
    // Boot partition decode of the standing address.
    assign boot = (address_bus <= bp_cmd_pkg::BOOT_LO_END) ||
                  (address_bus >= bp_cmd_pkg::BOOT_HI_START &&
                   address_bus <= bp_cmd_pkg::BOOT_HI_END);
    desel_hiz_a: assert property (chip_sel_n |-> !data_bus_d_oe)
        else $error("device drives the bus while deselected");
    pin_hiz_a: assert property (!warm_reset_pin_n |-> !data_bus_d_oe)
        else $error("device drives the bus while the reset pin is low");
    write_quiet_a: assert property (data_bus_d_oe |-> write_n)
        else $error("device drives the bus during a write strobe");
    strobe_excl_a: assert property (!write_n |-> !chip_sel_n && out_en_n)
        else $error("write strobe without select or with output enable");
    strobe_len_a: assert property ($fell(write_n) |-> !write_n[*6] ##1 write_n)
        else $error("write strobe is not six cycles long");
    // Write data is taken from the cycle before the strobe rises, while still driven.
    reset_busy_a: assert property ($rose(write_n) && !chip_sel_n && boot &&
        $past(data_bus) == bp_cmd_pkg::CMD_RESET |-> ##[1:8] busy)
        else $error("reset command did not start");
    first_idle_a: assert property ($rose(write_n) && !chip_sel_n && boot &&
        $past(data_bus) == bp_cmd_pkg::CMD_LOAD |-> !busy[*8])
        else $error("load started before its final cycle");
    data_idle_a: assert property ($rose(write_n) && !chip_sel_n && !boot
        |-> !busy[*8])
        else $error("write outside the boot partition started an operation");
    busy_len_a: assert property ($rose(busy) |-> ##[4:40] !busy)
        else $error("busy period out of bounds");
endmodule

// ===== tb/boot_partition_command_port_tb.sv
// Self-checking bench for the host and device ends joined by the bus.
`timescale 1ns/1ps
module boot_partition_command_port_tb;
    // Identity codes are arbitrary values.
    localparam logic [15:0] MAKER = 16'hA5C3;
    localparam logic [15:0] DEV   = 16'h3C5A;
    logic        core_clk;
    logic        reset;
    logic [15:0] sw_addr;
    logic [15:0] sw_wdata;
    logic        sw_wr;
    logic        sw_rd;
    logic [15:0] sw_rdata;
    logic        sw_busy;
    logic [1:0]  ecc_sel;
    logic [3:0]  ecc_lane;
    logic        ecc_valid;
    logic        locked;
    logic [15:0] block_addr;
    logic [5:0]  page;
    logic        load_done;
    logic [15:0] rd;
    int          mismatches = 0;
    int          check_count = 0;
    int          loads = 0;
    int          cycles = 0;

    bp_bus_if bus ();
    bp_cmd_device #(.MAKER_ID(MAKER), .DEVICE_ID(DEV)) bp_cmd_device_inst (
        .core_clk(core_clk), .reset(reset), .bus(bus), .ecc_sel_in(ecc_sel),
        .ecc_lane_in(ecc_lane), .ecc_valid_in(ecc_valid), .block_locked(locked),
        .block_addr_field(block_addr), .page_addr_field(page), .load_done(load_done));
    bp_cmd_host bp_cmd_host_inst (
        .core_clk(core_clk), .reset(reset), .bus(bus), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .sw_busy(sw_busy));
    bp_cmd_props bp_cmd_props_inst (
        .core_clk(core_clk), .reset(reset), .chip_sel_n(bus.chip_sel_n),
        .out_en_n(bus.out_en_n), .write_n(bus.write_n),
        .warm_reset_pin_n(bus.warm_reset_pin_n), .address_bus(bus.address_bus),
        .data_bus_d_oe(bus.data_bus_d_oe), .busy(bus.busy), .data_bus(bus.data_bus));

    // Clock at 50 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Counts finished loads; the ceiling cuts a hang short as a failure.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (load_done === 1'b1)
            loads <= loads + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One order to the host end; waits until both ends are idle again.
    task automatic order(input logic [15:0] a, input logic [15:0] d, input logic w);
        int n;
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= w;
        sw_rd    <= !w;
        @(posedge core_clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        repeat (2) @(posedge core_clk);
        n = 0;
        while ((sw_busy !== 1'b0 || bus.busy !== 1'b0) && n < 200)
        begin
            @(posedge core_clk);
            n++;
        end
        // One more edge lets the load counter take the last done pulse.
        @(posedge core_clk);
        rd = sw_rdata;
    endtask

    task automatic load(input logic [15:0] a);
        order(a, bp_cmd_pkg::CMD_LOAD, 1'b1);
        order(a, bp_cmd_pkg::CMD_LOAD_2ND, 1'b1);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence; each order waits for idle, so no request is ever refused.
    initial
    begin
        reset = 1'b1;
        sw_addr = 16'h0000;
        sw_wdata = 16'h0000;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        ecc_sel = bp_cmd_pkg::SEL_WORD3;
        ecc_lane = 4'hA;
        ecc_valid = 1'b1;
        locked = 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        order(bp_cmd_pkg::ECC_SPARE3_ADDR, 16'h0000, 1'b0);
        check(rd, bp_cmd_pkg::ECC_RESET_VAL);
        order(16'h0000, 16'h0000, 1'b0);
        check(rd, 16'h0000);
        check(block_addr, 16'h0000);
        // Just past each boot range, command codes are stored as plain data.
        order(16'h0200, bp_cmd_pkg::CMD_LOAD, 1'b1);
        order(16'h8010, bp_cmd_pkg::CMD_RESET, 1'b1);
        order(16'h0200, 16'h0000, 1'b0);
        check(rd, bp_cmd_pkg::CMD_LOAD);
        order(16'h8010, 16'h0000, 1'b0);
        check(rd, bp_cmd_pkg::CMD_RESET);
        check(16'(loads), 16'h0000);
        load(16'h800F);
        check(16'(loads), 16'h0001);
        check({10'h000, page}, 16'h0001);
        order(16'h0000, 16'h0000, 1'b0);
        check(rd, 16'h0000);
        order(bp_cmd_pkg::ECC_SPARE3_ADDR, 16'h0000, 1'b0);
        check(rd, {10'h000, bp_cmd_pkg::SEL_WORD3, 4'hA});
        ecc_sel <= bp_cmd_pkg::SEL_WORD2;
        ecc_lane <= 4'h3;
        load(16'h01FF);
        order(bp_cmd_pkg::ECC_SPARE3_ADDR, 16'h0000, 1'b0);
        check(rd, {10'h000, bp_cmd_pkg::SEL_WORD2, 4'h3});
        // A wrong second cycle aborts; the next full load still runs.
        order(16'h0000, bp_cmd_pkg::CMD_LOAD, 1'b1);
        order(16'h0000, 16'h1234, 1'b1);
        check(16'(loads), 16'h0002);
        load(16'h8000);
        check({10'h000, page}, 16'h0003);
        // Identification, ended by a data write; the command cleared the result.
        order(16'h0000, bp_cmd_pkg::CMD_IDENT, 1'b1);
        order(bp_cmd_pkg::ID_MAKER_ADDR, 16'h0000, 1'b0);
        check(rd, MAKER);
        order(bp_cmd_pkg::ID_DEVICE_ADDR, 16'h0000, 1'b0);
        check(rd, DEV);
        // The protect word comes from the lock input, which was set high before the command.
        order(bp_cmd_pkg::ID_WP_ADDR, 16'h0000, 1'b0);
        check(rd, 16'h0001);
        order(16'h0300, 16'h1111, 1'b1);
        order(16'h0000, 16'h0000, 1'b0);
        check(rd, 16'h0000);
        order(bp_cmd_pkg::ECC_SPARE3_ADDR, 16'h0000, 1'b0);
        check(rd, bp_cmd_pkg::ECC_RESET_VAL);
        order(16'h0010, bp_cmd_pkg::CMD_RESET, 1'b1);
        check({10'h000, page}, 16'h0000);
        // The page count wraps inside the block after 64 loads.
        repeat (63) load(16'h0000);
        check({10'h000, page}, 16'h003F);
        load(16'h0000);
        check({10'h000, page}, 16'h0000);
        check(block_addr, 16'h0000);
        check(16'(loads), 16'h0043);
        conclude();
    end
endmodule
